// ==== hdl/rbc_remap_boot_control.sv ====
// APB register bank steering remap, high-vector select and boot-from-instruction-memory
//
// Overview of operation
// RULE1 - APB slave, host uses whole-word transfers only
// RULE2 - Only first remap write after bus reset counts
// RULE3 - Any remap write raises remap, bit value ignored
// RULE4 - Remap output stays high until next reset
// RULE5 - Fabric maps vectors to ROM or SRAM bank
// RULE6 - Bus reset clears remap; chip reset does not
// RULE7 - Chip reset loads vector select from strap
// RULE8 - Vector-select bit 0 read-write, drives output
// RULE9 - Vector-select upper bits read strap, ignore writes
// RULE10 - Boot bit 0 read-write, drives boot output
// RULE11 - Boot upper bits ignore writes, read zero
// RULE12 - Boot bit cleared by chip reset only
// RULE13 - Core places vectors low or high by input
// RULE14 - Core enables instruction memory when boot high
// RULE15 - Host avoids reserved offsets zero and 0x10-0xFFF
// RULE16 - Bus reset wider; chip reset skips software reset
// RULE17 - No wait states, never a slave error
`timescale 1ns/1ps
`default_nettype none

module rbc_remap_boot_control
(
  // Clock and resets
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          chip_internal_reset_n,
  // Strap pin
  input  wire logic                          vector_select_strap,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [rbc_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [rbc_pkg::DATA_W-1:0]    pwdata,
  output logic      [rbc_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Sideband outputs
  output logic                               remap,
  output logic                               vector_select,
  output logic                               boot_from_instr_mem
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [rbc_pkg::DATA_W-1:0] remap_control_r;  // Value of the first write
  logic                       remap_done_r;     // Remap output level
  logic                       vector_high_bit_r;
  logic                       strap_level_r;    // Strap caught at chip reset
  logic                       itcm_boot_bit_r;
  logic [rbc_pkg::DATA_W-1:0] prdata_r;
  logic [rbc_pkg::DATA_W-1:0] read_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word decode; lane sub-addressing is not supported since the host
  // only issues full words
  function automatic logic hit(input logic [rbc_pkg::ADDR_W-1:0] a,
                               input logic [rbc_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  wire logic setup_phase = psel && !penable;
  wire logic wr_access   = psel && penable && pwrite;      // RULE1
  wire logic sel_remap   = hit(paddr, rbc_pkg::OFS_REMAP_CONTROL);
  wire logic sel_vector  = hit(paddr, rbc_pkg::OFS_VECTOR_HIGH);
  wire logic sel_itcm    = hit(paddr, rbc_pkg::OFS_ITCM_BOOT);
  wire logic wr_remap    = wr_access && sel_remap;
  wire logic wr_vector   = wr_access && sel_vector;
  wire logic wr_itcm     = wr_access && sel_itcm;
  // Only an unlatched remap write is honoured
  wire logic remap_take  = wr_remap && !remap_done_r;     // RULE2

  // Read mux: upper bits of vector register mirror the strap, boot
  // register upper bits and unmapped holes read zero
  always_comb
  begin
    if (sel_remap)
    begin
      read_nxt = remap_control_r;
    end
    else if (sel_vector)
    begin
      read_nxt = {{(rbc_pkg::DATA_W-1){strap_level_r}}, vector_high_bit_r}; // RULE9
    end
    else if (sel_itcm)
    begin
      read_nxt = {{(rbc_pkg::DATA_W-1){1'b0}}, itcm_boot_bit_r};            // RULE11
    end
    else
    begin
      // Reserved holes answer quietly with zero
      read_nxt = rbc_pkg::READ_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------
  // Bus-reset domain: remap register
  // ----------------------------------------------------------------
  // Cleared only by the bus reset, which software reset also drives
  always_ff @(posedge sys_clk)
  begin
    if (rst)                                               // RULE6 RULE16
    begin
      remap_control_r <= rbc_pkg::RST_REMAP_CONTROL;
      remap_done_r    <= rbc_pkg::RST_REMAP_DONE;
    end
    else if (remap_take)
    begin
      // Any written value raises remap; later writes are dropped
      remap_control_r <= pwdata;                           // RULE2
      remap_done_r    <= 1'b1;                             // RULE3 RULE4
    end
  end

  // ----------------------------------------------------------------
  // Chip-reset domain: vector select and instruction-memory boot
  // ----------------------------------------------------------------
  // Kept through a bus reset so a software reset can reboot from
  // instruction memory with the vector choice intact
  always_ff @(posedge sys_clk)
  begin
    if (!chip_internal_reset_n)                            // RULE16
    begin
      strap_level_r     <= vector_select_strap;            // RULE7
      vector_high_bit_r <= vector_select_strap;            // RULE7
      itcm_boot_bit_r   <= rbc_pkg::RST_ITCM_BOOT;         // RULE12
    end
    else
    begin
      if (wr_vector)
      begin
        vector_high_bit_r <= pwdata[rbc_pkg::CTRL_BIT];    // RULE8
      end
      if (wr_itcm)
      begin
        itcm_boot_bit_r <= pwdata[rbc_pkg::CTRL_BIT];      // RULE10
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Captured in the setup phase so data is ready with no wait state
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prdata_r <= rbc_pkg::RST_READ_DATA;
    end
    else if (setup_phase && !pwrite)
    begin
      prdata_r <= read_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata              = prdata_r;
  assign pready              = 1'b1;                       // RULE17
  assign pslverr             = 1'b0;                       // RULE17
  assign remap               = remap_done_r;               // RULE3 RULE5
  assign vector_select       = vector_high_bit_r;          // RULE8 RULE13
  assign boot_from_instr_mem = itcm_boot_bit_r;            // RULE10 RULE14

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // First remap write raises the output next cycle
  property p_remap_first;
    @(posedge sys_clk) disable iff (rst)
    (wr_remap && !remap) |=> remap && (remap_control_r == $past(pwdata));
  endproperty
  a_remap_first: assert property (p_remap_first) // RULE2
    else $error("first remap write did not take effect");

  // Remap ignores later writes, whatever their data
  property p_remap_ignore;
    @(posedge sys_clk) disable iff (rst)
    (wr_remap && remap) |=> $stable(remap_control_r);
  endproperty
  a_remap_ignore: assert property (p_remap_ignore) // RULE2
    else $error("later remap write changed the register");

  // Writing zero still raises remap
  property p_remap_zero;
    @(posedge sys_clk) disable iff (rst)
    (wr_remap && (pwdata[rbc_pkg::CTRL_BIT] == 1'b0)) |=> remap;
  endproperty
  a_remap_zero: assert property (p_remap_zero) // RULE3
    else $error("write of zero did not raise remap");

  // Remap stays high for the eight cycles from its rise unless bus reset
  property p_remap_sticky;
    @(posedge sys_clk) disable iff (rst)
    $rose(remap) |-> remap [*8];
  endproperty
  a_remap_sticky: assert property (p_remap_sticky) // RULE4
    else $error("remap dropped without reset");

  // Bus reset clears remap, chip reset leaves it alone
  property p_remap_reset;
    @(posedge sys_clk) disable iff (1'b0)
    (rst |=> !remap && (remap_control_r == rbc_pkg::RST_REMAP_CONTROL)) and
    ((!rst && chip_internal_reset_n == 1'b0 && !wr_remap) |=> $stable(remap));
  endproperty
  a_remap_reset: assert property (p_remap_reset) // RULE6
    else $error("remap reset behaviour wrong");

  // Chip reset loads vector select from the strap
  property p_vector_strap;
    @(posedge sys_clk) disable iff (1'b0)
    !chip_internal_reset_n |=> vector_select == $past(vector_select_strap);
  endproperty
  a_vector_strap: assert property (p_vector_strap) // RULE7
    else $error("vector select not loaded from strap");

  // Written bit 0 drives the vector select output
  property p_vector_write;
    @(posedge sys_clk) disable iff (!chip_internal_reset_n)
    wr_vector |=> vector_select == $past(pwdata[rbc_pkg::CTRL_BIT]);
  endproperty
  a_vector_write: assert property (p_vector_write) // RULE8
    else $error("vector select write not applied");

  // Vector register upper bits return the strap level
  property p_vector_upper;
    @(posedge sys_clk) disable iff (rst || !chip_internal_reset_n)
    (setup_phase && !pwrite && sel_vector) |=>
      prdata[rbc_pkg::DATA_W-1:rbc_pkg::UPPER_LSB] == {(rbc_pkg::DATA_W-1){strap_level_r}};
  endproperty
  a_vector_upper: assert property (p_vector_upper) // RULE9
    else $error("vector upper bits wrong on read");

  // Boot bit write drives the output, upper bits read zero
  property p_itcm_write;
    @(posedge sys_clk) disable iff (!chip_internal_reset_n)
    wr_itcm |=> boot_from_instr_mem == $past(pwdata[rbc_pkg::CTRL_BIT]);
  endproperty
  a_itcm_write: assert property (p_itcm_write) // RULE10
    else $error("boot bit write not applied");

  property p_itcm_upper;
    @(posedge sys_clk) disable iff (rst)
    (setup_phase && !pwrite && sel_itcm) |=>
      prdata[rbc_pkg::DATA_W-1:rbc_pkg::UPPER_LSB] == '0;
  endproperty
  a_itcm_upper: assert property (p_itcm_upper) // RULE11
    else $error("boot upper bits not zero");

  // Bus reset alone keeps the boot bit
  property p_itcm_keep;
    @(posedge sys_clk) disable iff (1'b0)
    (rst && chip_internal_reset_n && !wr_itcm) |=>
      $stable(boot_from_instr_mem);
  endproperty
  a_itcm_keep: assert property (p_itcm_keep) // RULE12
    else $error("bus reset disturbed boot bit");

  // Every access completes at once without error
  property p_no_wait;
    @(posedge sys_clk) disable iff (rst)
    psel |-> pready && !pslverr;
  endproperty
  a_no_wait: assert property (p_no_wait) // RULE17
    else $error("wait state or error signalled");

endmodule

`default_nettype wire

// ==== hdl/rbc_pkg.sv ====
// Package of offsets, widths and reset values for the remap and boot control block
package rbc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;  // Block window is 4 KiB
  localparam int unsigned DATA_W = 32;  // Full word registers only

  // ----------------------------------------------------------------
  // Register offsets (byte addresses inside the window)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_REMAP_CONTROL = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_VECTOR_HIGH   = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_ITCM_BOOT     = 12'h00C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_BIT  = 0;  // Bit 0 of each control register
  localparam int unsigned UPPER_LSB = 1;  // Lowest of the upper bits 31..1

  // ----------------------------------------------------------------
  // Reset and fill values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_REMAP_CONTROL = 32'h0000_0000;
  localparam logic              RST_ITCM_BOOT     = 1'b0;
  localparam logic              RST_REMAP_DONE    = 1'b0;
  localparam logic [DATA_W-1:0] READ_UNMAPPED     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_READ_DATA     = 32'h0000_0000;

endpackage

// ==== verif/rbc_core_model.sv ====
// Behavioural model of the core and fabric that consume the boot sideband outputs
`timescale 1ns/1ps
`default_nettype none

module rbc_core_model
(
  // Clock and core reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Sideband inputs from the block
  input  wire logic        remap,
  input  wire logic        vector_select,
  input  wire logic        boot_from_instr_mem,
  // Observed boot state
  output logic      [31:0] vector_base,
  output logic             itcm_on,
  output logic             vec_in_sram
);
  // --------------------------------------------------------------
  // Fabric and core view
  // --------------------------------------------------------------
  // Fabric steers the vector area to SRAM bank zero while remap is high
  assign vec_in_sram = remap;
  // Core looks at its straps only while held in reset, so late changes stay unseen
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      vector_base <= vector_select ? 32'hFFFF_0000 : 32'h0000_0000;
      itcm_on     <= boot_from_instr_mem;
    end
  end
endmodule

`default_nettype wire

// ==== verif/rbc_remap_boot_control_tb_top.sv ====
// Self-checking testbench for the remap and boot control register bank
`timescale 1ns/1ps
`default_nettype none

module rbc_remap_boot_control_tb_top;
  // --------------------------------------------------------------
  // Signals, design and partner
  // --------------------------------------------------------------
  typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] r;} rbc_row_s;
  logic        sys_clk = 1'h0;  // 200 MHz clock
  logic        rst, chip_internal_reset_n, vector_select_strap;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, vector_base;
  logic        remap, vector_select, boot_from_instr_mem, itcm_on, vec_in_sram;
  int          n_fail = 0;
  int          checks_done = 0;
  // Write then read back; the host stays off reserved offsets, so only mapped ones appear
  rbc_row_s    rows [6] = '{
    '{12'h008, 32'h0000_0000, 32'hFFFF_FFFE}, '{12'h008, 32'h0000_0003, 32'hFFFF_FFFF},
    '{12'h00C, 32'hFFFF_FFFE, 32'h0000_0000}, '{12'h00C, 32'hFFFF_FFFF, 32'h0000_0001},
    '{12'h008, 32'hFFFF_FFFE, 32'hFFFF_FFFE}, '{12'h008, 32'h0000_0001, 32'hFFFF_FFFF}};

  always #2.5 sys_clk = ~sys_clk;

  rbc_remap_boot_control dut (.sys_clk(sys_clk), .rst(rst),
    .chip_internal_reset_n(chip_internal_reset_n), .vector_select_strap(vector_select_strap),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .remap(remap),
    .vector_select(vector_select), .boot_from_instr_mem(boot_from_instr_mem));
  rbc_core_model core (.sys_clk(sys_clk), .rst(rst), .remap(remap),
    .vector_select(vector_select), .boot_from_instr_mem(boot_from_instr_mem),
    .vector_base(vector_base), .itcm_on(itcm_on), .vec_in_sram(vec_in_sram));

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; answer taken at the access-phase edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    psel <= 1'h1; pwrite <= wr; paddr <= a; pwdata <= w; penable <= 1'h0;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    d = prdata;
    chk("pready", 32'h0000_0001, {31'h0000_0000, pready});
    chk("pslverr", 32'h0000_0000, {31'h0000_0000, pslverr});
    psel <= 1'h0; penable <= 1'h0;
  endtask
  // Outputs settle one edge after a write or reset
  task automatic outs(input logic [2:0] e);
    @(posedge sys_clk);
    #1;
    chk("outputs", {29'h0000_0000, e}, {29'h0000_0000, remap, vector_select, boot_from_instr_mem});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial
  begin
    rst = 1'h1; chip_internal_reset_n = 1'h0; vector_select_strap = 1'h1;
    psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h000; pwdata = 32'h0000_0000;
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0; chip_internal_reset_n <= 1'h1;
    outs(3'h2);
    chk("vector base", 32'hFFFF_0000, vector_base);
    chk("itcm off", 32'h0000_0000, {31'h0000_0000, itcm_on});
    for (int i = 0; i < 6; i++)
    begin
      apb(1'h1, rows[i].a, rows[i].w);
      apb(1'h0, rows[i].a, 32'h0000_0000);
      chk("row read", rows[i].r, d);
    end
    outs(3'h3);
    // Remap written with bit 0 clear still raises remap; later writes drop
    apb(1'h1, 12'h004, 32'hFFFF_FFFE);
    outs(3'h7);
    chk("vec in sram", 32'h0000_0001, {31'h0000_0000, vec_in_sram});
    apb(1'h1, 12'h004, 32'h0000_0001);
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk("remap word", 32'hFFFF_FFFE, d);
    // Bus reset alone: remap cleared, boot bit kept for the reboot
    rst <= 1'h1;
    @(posedge sys_clk);
    rst <= 1'h0;
    outs(3'h3);
    chk("itcm on", 32'h0000_0001, {31'h0000_0000, itcm_on});
    chk("vec in rom", 32'h0000_0000, {31'h0000_0000, vec_in_sram});
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk("remap cleared", 32'h0000_0000, d);
    apb(1'h1, 12'h004, 32'h0000_1234);
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk("remap again", 32'h0000_1234, d);
    // Chip reset alone with strap low: remap survives, straps reload
    vector_select_strap <= 1'h0; chip_internal_reset_n <= 1'h0;
    @(posedge sys_clk);
    chip_internal_reset_n <= 1'h1;
    outs(3'h4);
    apb(1'h0, 12'h008, 32'h0000_0000);
    chk("vector reg", 32'h0000_0000, d);
    // Core reset with the low strap value in place: vectors move to address zero
    rst <= 1'h1;
    @(posedge sys_clk);
    rst <= 1'h0;
    outs(3'h0);
    chk("vector base low", 32'h0000_0000, vector_base);
    give_verdict;
  end

  initial
  begin
    #20000;
    n_fail++;
    give_verdict;
  end
endmodule

`default_nettype wire
